/* File: fpp_cfg_host.sv */
// Host end: requests configuration and streams words to the device
`timescale 1ns/100ps
`include "fpp_cfg_params.svh"
module fpp_cfg_host
  import fpp_cfg_pkg::*;
#(
  parameter int DATA_W      = `FPP_DATA_W,
  parameter int DEPTH       = `FPP_FIFO_DEPTH,
  parameter int CLK_HALF    = `CONFIG_CLOCK_HALF_CYC,
  parameter int USR_HALF    = `USR_HALF_CYC,
  parameter int REQ_LOW_CYC = `CFG_LOW_CYC,
  parameter int CF2CK_CYC   = `CF2CK_CYC,
  parameter int ST2CK_CYC   = `ST2CK_CYC
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_start,
  input  wire logic              i_monitor_ready,
  input  wire logic              i_hold_ready,
  input  wire logic [DATA_W-1:0] i_word,
  input  wire logic              i_word_valid,
  output logic                   o_word_ready,
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_error,
  fpp_cfg_if.host                link
);
  localparam int CW = `CNT_W;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int FW = $clog2(DEPTH + 1);
  localparam int HW = 8;

  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic [PW-1:0]     wr_reg,     wr_next;
  logic [PW-1:0]     rd_reg,     rd_next;
  logic [FW-1:0]     fill_reg,   fill_next;
  logic              wrdy_reg,   wrdy_next;
  logic [1:0]        meta_reg;
  logic [1:0]        sync_reg;
  host_state_t       state_reg,  state_next;
  logic [CW-1:0]     cnt_reg,    cnt_next;
  logic [HW-1:0]     dcnt_reg,   dcnt_next;
  logic [HW-1:0]     ucnt_reg;
  logic              req_reg,    req_next;
  logic              config_clock_reg,   config_clock_next;
  logic              uclk_reg;
  logic              loaded_reg, loaded_next;
  logic              seen_reg,   seen_next;
  logic              fall_reg,   fall_next;
  logic [DATA_W-1:0] data_reg,   data_next;
  logic              hold_reg;
  logic              busy_reg;
  logic              done_reg,   done_next;
  logic              err_reg,    err_next;

  wire rdy_hi    = sync_reg[0];
  wire lc_hi     = sync_reg[1];
  wire half_end  = dcnt_reg == HW'(CLK_HALF - 1);
  wire uhalf_end = ucnt_reg == HW'(USR_HALF - 1);
  wire push      = i_word_valid & wrdy_reg;
  wire have_word = fill_reg != FW'(0);
  wire pop       = state_reg == H_SEND && !config_clock_reg && !loaded_reg && !lc_hi
                   && have_word;
  wire xfer_act  = state_reg == H_SEND || state_reg == H_FINISH;

  assign link.config_request_low = req_reg;
  assign link.config_clock       = config_clock_reg;
  assign link.data               = data_reg;
  assign link.init_user_clock    = uclk_reg;
  assign link.host_ready_oe      = hold_reg;
  assign o_word_ready            = wrdy_reg;
  assign o_busy                  = busy_reg;
  assign o_done                  = done_reg;
  assign o_error                 = err_reg;

  // Two-entry word buffer; ready drops when full
  always_comb begin
    wr_next   = wr_reg;
    rd_next   = rd_reg;
    fill_next = fill_reg;
    if (push) begin
      wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + PW'(1);
    end
    if (pop) begin
      rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + PW'(1);
    end
    if (push && !pop) begin
      fill_next = fill_reg + FW'(1);
    end else if (pop && !push) begin
      fill_next = fill_reg - FW'(1);
    end
    wrdy_next = fill_next != FW'(DEPTH);
  end

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    dcnt_next   = dcnt_reg;
    req_next    = req_reg;
    config_clock_next   = config_clock_reg;
    loaded_next = loaded_reg;
    seen_next   = seen_reg;
    fall_next   = fall_reg;
    data_next   = data_reg;
    done_next   = done_reg;
    err_next    = err_reg;
    unique case (state_reg)
      H_IDLE: begin
        req_next = 1'b1;
        if (i_start) begin
          state_next = H_REQ;
          req_next   = 1'b0;
          cnt_next   = '0;
          err_next   = 1'b0;
        end
      end
      H_REQ: begin
        cnt_next = cnt_reg + CW'(1);
        // Holding the start request stretches the low pulse
        if (cnt_reg >= CW'(REQ_LOW_CYC - 1) && !i_start) begin
          state_next = H_WAIT;
          req_next   = 1'b1;
          cnt_next   = '0;
          seen_next  = 1'b0;
        end
      end
      H_WAIT: begin
        cnt_next = cnt_reg + CW'(1);
        if (i_monitor_ready) begin
          if (!seen_reg && rdy_hi) begin
            seen_next = 1'b1;
            cnt_next  = '0;
          end
          if (seen_reg && cnt_reg >= CW'(ST2CK_CYC - 1)) begin
            state_next = H_SEND;
          end
        end else if (cnt_reg >= CW'(CF2CK_CYC - 1)) begin
          state_next = H_SEND;
        end
        config_clock_next   = 1'b0;
        dcnt_next   = '0;
        loaded_next = 1'b0;
      end
      H_SEND: begin
        if (!config_clock_reg && !loaded_reg && lc_hi) begin
          state_next = H_FINISH;
          dcnt_next  = '0;
          fall_next  = 1'b0;
        end else if (!config_clock_reg && !loaded_reg) begin
          if (have_word) begin
            data_next   = mem_reg[rd_reg];
            loaded_next = 1'b1;
            dcnt_next   = '0;
          end
        end else if (half_end) begin
          // One word per clock; rises only after a full low half
          config_clock_next = ~config_clock_reg;
          dcnt_next = '0;
          if (config_clock_reg) begin
            loaded_next = 1'b0;
          end
        end else begin
          dcnt_next = dcnt_reg + HW'(1);
        end
      end
      H_FINISH: begin
        if (half_end) begin
          config_clock_next = ~config_clock_reg;
          dcnt_next = '0;
          if (config_clock_reg) begin
            fall_next = 1'b1;
            if (fall_reg) begin
              state_next = H_DONE;
            end
          end
        end else begin
          dcnt_next = dcnt_reg + HW'(1);
        end
      end
      H_DONE: begin
        done_next = 1'b1;
        if (i_start) begin
          state_next = H_REQ;
          req_next   = 1'b0;
          cnt_next   = '0;
          done_next  = 1'b0;
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
    if (xfer_act && !rdy_hi) begin
      state_next  = H_REQ;
      req_next    = 1'b0;
      cnt_next    = '0;
      config_clock_next   = 1'b0;
      loaded_next = 1'b0;
      err_next    = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_word;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_reg   <= '0;
      rd_reg   <= '0;
      fill_reg <= '0;
      wrdy_reg <= 1'b0;
      meta_reg <= 2'b00;
      sync_reg <= 2'b00;
      hold_reg <= 1'b0;
    end else begin
      wr_reg   <= wr_next;
      rd_reg   <= rd_next;
      fill_reg <= fill_next;
      wrdy_reg <= wrdy_next;
      meta_reg <= {link.load_complete, link.device_ready_low};
      sync_reg <= meta_reg;
      hold_reg <= i_hold_ready;
    end
  end

  // Free-running user init clock
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ucnt_reg <= '0;
      uclk_reg <= 1'b0;
    end else if (uhalf_end) begin
      ucnt_reg <= '0;
      uclk_reg <= ~uclk_reg;
    end else begin
      ucnt_reg <= ucnt_reg + HW'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg  <= H_IDLE;
      cnt_reg    <= '0;
      dcnt_reg   <= '0;
      req_reg    <= 1'b1;
      config_clock_reg   <= 1'b0;
      loaded_reg <= 1'b0;
      seen_reg   <= 1'b0;
      fall_reg   <= 1'b0;
      data_reg   <= '0;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      err_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      dcnt_reg   <= dcnt_next;
      req_reg    <= req_next;
      config_clock_reg   <= config_clock_next;
      loaded_reg <= loaded_next;
      seen_reg   <= seen_next;
      fall_reg   <= fall_next;
      data_reg   <= data_next;
      busy_reg   <= state_next != H_IDLE && state_next != H_DONE;
      done_reg   <= done_next;
      err_reg    <= err_next;
    end
  end
endmodule

/* File: fpp_cfg_params.svh */
// Timing and size constants for the fast passive parallel configuration link
`ifndef FPP_CFG_PARAMS_SVH
`define FPP_CFG_PARAMS_SVH
`define CORE_MHZ          200
`define FPP_DATA_W        32
`define FPP_NUM_WORDS     16
`define FPP_FIFO_DEPTH    2
`define CNT_W             20
`define T_CF2CD_NS        600
`define CF2CD_CYC         ((`T_CF2CD_NS * `CORE_MHZ) / 1000)
`define T_CFG_US          2
`define CFG_LOW_CYC       (`T_CFG_US * `CORE_MHZ)
`define T_STATUS_MIN_US   268
`define STATUS_MIN_CYC    (`T_STATUS_MIN_US * `CORE_MHZ)
`define T_STATUS_MAX_US   1506
`define STATUS_MAX_CYC    (`T_STATUS_MAX_US * `CORE_MHZ)
`define T_CF2CK_US        1506
`define CF2CK_CYC         (`T_CF2CK_US * `CORE_MHZ)
`define T_ST2CK_US        2
`define ST2CK_CYC         (`T_ST2CK_US * `CORE_MHZ)
`define T_CD2UM_MIN_US    175
`define T_CD2UM_MAX_US    437
`define INIT_OSC_CYC      (`T_CD2UM_MIN_US * `CORE_MHZ)
`define CONFIG_CLOCK_MAX_MHZ_NARROW 125
`define CONFIG_CLOCK_MAX_MHZ_WIDE 100
`define CU_PERIODS        4
`define CU_CYC            ((`CU_PERIODS * `CORE_MHZ + `CONFIG_CLOCK_MAX_MHZ_WIDE - 1) / `CONFIG_CLOCK_MAX_MHZ_WIDE)
`define USR_INIT_PERIODS  8576
`define CONFIG_CLOCK_HALF_MIN     ((`CORE_MHZ + 2 * `CONFIG_CLOCK_MAX_MHZ_WIDE - 1) / (2 * `CONFIG_CLOCK_MAX_MHZ_WIDE))
`define CONFIG_CLOCK_HALF_CYC     8
`define USR_HALF_CYC      16
`endif

/* File: fpp_cfg_pkg.sv */
// State types for both ends of the configuration link
package fpp_cfg_pkg;
  typedef enum logic [1:0] {
    DEV_RESET = 2'b00,
    DEV_LOAD  = 2'b01,
    DEV_INIT  = 2'b10,
    DEV_USER  = 2'b11
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_REQ    = 3'b001,
    H_WAIT   = 3'b010,
    H_SEND   = 3'b011,
    H_FINISH = 3'b100,
    H_DONE   = 3'b101
  } host_state_t;
endpackage

/* File: fpp_cfg_if.sv */
// Pins between configuration host and device
`timescale 1ns/100ps
`include "fpp_cfg_params.svh"
interface fpp_cfg_if #(parameter int DATA_W = `FPP_DATA_W);
  logic              config_request_low;
  logic              config_clock;
  logic [DATA_W-1:0] data;
  logic              init_user_clock;
  logic              load_complete;
  logic              dev_ready_oe;
  logic              host_ready_oe;
  logic              device_ready_low;
  // Open-drain ready line: low while either end pulls it
  assign device_ready_low = ~(dev_ready_oe | host_ready_oe);
  modport dev (input  config_request_low, config_clock, data, init_user_clock,
               input  device_ready_low,
               output load_complete, dev_ready_oe);
  modport host (output config_request_low, config_clock, data, init_user_clock,
                output host_ready_oe,
                input  load_complete, device_ready_low);
endinterface

/* File: fpp_cfg_device.sv */
// Device end: receives configuration words and walks to user mode
`timescale 1ns/100ps
`include "fpp_cfg_params.svh"
module fpp_cfg_device
  import fpp_cfg_pkg::*;
#(
  parameter int DATA_W           = `FPP_DATA_W,
  parameter int NUM_WORDS        = `FPP_NUM_WORDS,
  parameter int STATUS_MIN_CYC   = `STATUS_MIN_CYC,
  parameter int INIT_OSC_CYC     = `INIT_OSC_CYC,
  parameter int USR_INIT_PERIODS = `USR_INIT_PERIODS
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_use_user_clock,
  fpp_cfg_if.dev                 link,
  output logic      [DATA_W-1:0] o_cfg_word,
  output logic                   o_cfg_valid,
  output logic                   o_user_mode,
  output logic                   o_init_clock_enable
);
  localparam int SW   = DATA_W + 3;
  localparam int CW   = `CNT_W;
  localparam int WC_W = $clog2(NUM_WORDS + 1);

  logic [SW-1:0]     meta_reg;
  logic [SW-1:0]     sync_reg;
  logic              clk_prev_reg;
  logic              uclk_prev_reg;
  dev_state_t        state_reg,    state_next;
  logic [CW-1:0]     cnt_reg,      cnt_next;
  logic [WC_W-1:0]   word_cnt_reg, word_cnt_next;
  logic [1:0]        fall_reg,     fall_next;
  logic              rdy_oe_reg,   rdy_oe_next;
  logic              done_reg,     done_next;
  logic              user_reg,     user_next;
  logic              en_reg,       en_next;
  logic              valid_reg,    valid_next;
  logic [DATA_W-1:0] word_reg,     word_next;

  wire [SW-1:0] pins = {link.data, link.init_user_clock, link.config_clock,
                        link.config_request_low};
  wire              req_act   = ~sync_reg[0];
  wire              config_clock_rise = sync_reg[1] & ~clk_prev_reg;
  wire              config_clock_fall = ~sync_reg[1] & clk_prev_reg;
  wire              uclk_rise = sync_reg[2] & ~uclk_prev_reg;
  wire [DATA_W-1:0] data_s    = sync_reg[SW-1:3];
  wire              last_word = word_cnt_reg == WC_W'(NUM_WORDS - 1);
  wire              fall_done = fall_reg == 2'd2;
  wire              min_held  = cnt_reg == CW'(STATUS_MIN_CYC);

  assign link.dev_ready_oe  = rdy_oe_reg;
  assign link.load_complete = done_reg;
  assign o_cfg_word          = word_reg;
  assign o_cfg_valid         = valid_reg;
  assign o_user_mode         = user_reg;
  assign o_init_clock_enable = en_reg;

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    word_cnt_next = word_cnt_reg;
    fall_next     = fall_reg;
    rdy_oe_next   = rdy_oe_reg;
    done_next     = done_reg;
    user_next     = user_reg;
    en_next       = en_reg;
    valid_next    = 1'b0;
    word_next     = word_reg;
    unique case (state_reg)
      DEV_RESET: begin
        rdy_oe_next = 1'b1;
        done_next   = 1'b0;
        user_next   = 1'b0;
        en_next     = 1'b0;
        if (!min_held) begin
          cnt_next = cnt_reg + CW'(1);
        end
        if (!req_act && min_held) begin
          state_next    = DEV_LOAD;
          rdy_oe_next   = 1'b0;
          word_cnt_next = '0;
        end
      end
      DEV_LOAD: begin
        if (config_clock_rise) begin
          // Words pass through untouched
          valid_next    = 1'b1;
          word_next     = data_s;
          word_cnt_next = word_cnt_reg + WC_W'(1);
          if (last_word) begin
            done_next  = 1'b1;
            state_next = DEV_INIT;
            cnt_next   = '0;
            fall_next  = 2'd0;
          end
        end
      end
      DEV_INIT: begin
        if (config_clock_fall && !fall_done) begin
          fall_next = fall_reg + 2'd1;
        end
        if (en_reg) begin
          if (uclk_rise) begin
            cnt_next = cnt_reg + CW'(1);
            // First rise only opens the first whole period
            if (cnt_reg == CW'(USR_INIT_PERIODS)) begin
              state_next = DEV_USER;
              user_next  = 1'b1;
            end
          end
        end else begin
          cnt_next = cnt_reg + CW'(1);
          if (fall_done && i_use_user_clock && cnt_reg >= CW'(`CU_CYC)) begin
            en_next  = 1'b1;
            cnt_next = '0;
          end else if (fall_done && !i_use_user_clock
                       && cnt_reg >= CW'(INIT_OSC_CYC)) begin
            state_next = DEV_USER;
            user_next  = 1'b1;
          end
        end
      end
      DEV_USER: begin
        user_next = 1'b1;
      end
    endcase
    if (req_act && state_reg != DEV_RESET) begin
      state_next  = DEV_RESET;
      cnt_next    = '0;
      rdy_oe_next = 1'b1;
      done_next   = 1'b0;
      user_next   = 1'b0;
      en_next     = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg      <= '0;
      sync_reg      <= '0;
      clk_prev_reg  <= 1'b0;
      uclk_prev_reg <= 1'b0;
    end else begin
      meta_reg      <= pins;
      sync_reg      <= meta_reg;
      clk_prev_reg  <= sync_reg[1];
      uclk_prev_reg <= sync_reg[2];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg    <= DEV_RESET;
      cnt_reg      <= '0;
      word_cnt_reg <= '0;
      fall_reg     <= 2'd0;
      rdy_oe_reg   <= 1'b1;
      done_reg     <= 1'b0;
      user_reg     <= 1'b0;
      en_reg       <= 1'b0;
      valid_reg    <= 1'b0;
      word_reg     <= '0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      word_cnt_reg <= word_cnt_next;
      fall_reg     <= fall_next;
      rdy_oe_reg   <= rdy_oe_next;
      done_reg     <= done_next;
      user_reg     <= user_next;
      en_reg       <= en_next;
      valid_reg    <= valid_next;
      word_reg     <= word_next;
    end
  end
endmodule

/* File: fpp_cfg_link_properties.sv */
// Concurrent checks on the configuration link pins
`timescale 1ns/100ps
module fpp_cfg_link_properties #(
  parameter int DATA_W         = 32,
  parameter int NUM_WORDS      = 16,
  parameter int STATUS_MIN_CYC = 50,
  parameter int REQ_LOW_CYC    = 20,
  parameter int ST2CK_CYC      = 20
) (
  input wire logic              i_core_clk,
  input wire logic              i_rst_n,
  input wire logic              config_request_low,
  input wire logic              config_clock,
  input wire logic [DATA_W-1:0] data,
  input wire logic              load_complete,
  input wire logic              dev_ready_oe,
  input wire logic              device_ready_low
);
  localparam int ANS_MAX = 120;
  localparam int REL_MAX = 300;
  logic [15:0] low_cnt_reg;
  logic [15:0] oe_cnt_reg;
  logic [15:0] hi_cnt_reg;
  logic [7:0]  rise_cnt_reg;
  logic        clk_d_reg;
  logic        first_reg;
  wire         clk_rise = config_clock & ~clk_d_reg;

  // Lengths of the current low request, device pull and ready-high stretch
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_reg <= 16'h0;
      oe_cnt_reg  <= 16'h0;
      hi_cnt_reg  <= 16'h0;
    end else begin
      low_cnt_reg <= config_request_low ? 16'h0 : low_cnt_reg + 16'h1;
      oe_cnt_reg  <= dev_ready_oe ? oe_cnt_reg + 16'h1 : 16'h0;
      hi_cnt_reg  <= device_ready_low ? hi_cnt_reg + 16'h1 : 16'h0;
    end
  end

  // Clock rises since the request and first-rise marker
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_d_reg    <= 1'b0;
      rise_cnt_reg <= 8'h0;
      first_reg    <= 1'b0;
    end else begin
      clk_d_reg    <= config_clock;
      rise_cnt_reg <= !config_request_low ? 8'h0 : rise_cnt_reg + {7'h0, clk_rise};
      first_reg    <= !config_request_low | (first_reg & ~clk_rise);
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_fall;
    $fell(config_clock);
  endsequence

  property p_req_low_min;
    $rose(config_request_low) |-> low_cnt_reg >= REQ_LOW_CYC - 1;
  endproperty
  a_req_low_min: assert property (p_req_low_min)
    else $error("request low pulse too short");

  property p_load_drop;
    $fell(config_request_low) |-> ##[1:ANS_MAX] !load_complete;
  endproperty
  a_load_drop: assert property (p_load_drop)
    else $error("load complete not dropped in time");

  property p_ready_drop;
    $fell(config_request_low) |-> ##[1:ANS_MAX] dev_ready_oe;
  endproperty
  a_ready_drop: assert property (p_ready_drop)
    else $error("ready not pulled low in time");

  property p_ready_min;
    $fell(dev_ready_oe) |-> oe_cnt_reg >= STATUS_MIN_CYC - 4;
  endproperty
  a_ready_min: assert property (p_ready_min)
    else $error("ready low pulse too short");

  property p_ready_rel;
    $rose(config_request_low) |-> ##[1:REL_MAX] !dev_ready_oe;
  endproperty
  a_ready_rel: assert property (p_ready_rel)
    else $error("ready not released after request");

  property p_full_load;
    $rose(load_complete) |-> rise_cnt_reg == NUM_WORDS;
  endproperty
  a_full_load: assert property (p_full_load)
    else $error("load complete before all words");

  property p_two_falls;
    // Skips the fall that ends the last word
    $rose(load_complete) |-> ##[8:60] s_fall ##[1:40] s_fall;
  endproperty
  a_two_falls: assert property (p_two_falls)
    else $error("missing falling edges after load");

  property p_data_hold;
    config_clock |-> $stable(data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data moved while clock high");

  property p_clk_high;
    $rose(config_clock) |-> config_clock [*8] ##1 !config_clock;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("clock high time wrong");

  property p_first_clk;
    $rose(config_clock) && first_reg |-> hi_cnt_reg >= ST2CK_CYC;
  endproperty
  a_first_clk: assert property (p_first_clk)
    else $error("first clock too soon after ready");
endmodule

/* File: fast_parallel_config_sequencer_tb.sv */
// Bench joining host and device ends with a reference model
`timescale 1ns/100ps
`include "fpp_cfg_params.svh"
module fast_parallel_config_sequencer_tb;
  import fpp_cfg_pkg::*;
  localparam int NW = 16, SMIN = 50, OSC = 40, UPER = 8, CF = 300, RLOW = 20, ST = 20;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n    = 1'b0;
  logic        use_uclk   = 1'b0;
  logic        start      = 1'b0;
  logic        mon        = 1'b0;
  logic        hold       = 1'b0;
  logic        wvalid     = 1'b0;
  logic [31:0] word       = 32'h0;
  logic [31:0] cfg_word;
  logic        cfg_valid, user_mode, clk_en, word_ready, busy, done, error;
  logic [15:0] lfsr = 16'h0010;
  logic [31:0] q[$];
  logic        rq_d = 1'b1, ck_d = 1'b0, lc_d = 1'b0, um_d = 1'b0, en_d = 1'b0, first = 1'b0;
  int          fail_count = 0, checks = 0, nvalid = 0, refused = 0, exp_low = 0;
  int          req_len = 0, since_rq = 0, lc_t = 0, en_t = 0;

  always #2.5 i_core_clk = ~i_core_clk;

  fpp_cfg_if link ();
  fpp_cfg_device #(.NUM_WORDS(NW), .STATUS_MIN_CYC(SMIN), .INIT_OSC_CYC(OSC),
    .USR_INIT_PERIODS(UPER)) i_fpp_cfg_device (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_use_user_clock(use_uclk), .link(link), .o_cfg_word(cfg_word), .o_cfg_valid(cfg_valid),
    .o_user_mode(user_mode), .o_init_clock_enable(clk_en));
  fpp_cfg_host #(.REQ_LOW_CYC(RLOW), .CF2CK_CYC(CF), .ST2CK_CYC(ST)) i_fpp_cfg_host (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_start(start), .i_monitor_ready(mon),
    .i_hold_ready(hold), .i_word(word), .i_word_valid(wvalid), .o_word_ready(word_ready),
    .o_busy(busy), .o_done(done), .o_error(error), .link(link));
  fpp_cfg_link_properties #(.NUM_WORDS(NW), .STATUS_MIN_CYC(SMIN), .REQ_LOW_CYC(RLOW),
    .ST2CK_CYC(ST)) i_fpp_cfg_link_properties (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .config_request_low(link.config_request_low), .config_clock(link.config_clock),
    .data(link.data), .load_complete(link.load_complete), .dev_ready_oe(link.dev_ready_oe),
    .device_ready_low(link.device_ready_low));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic sel(input int s);
    return s == 0 ? done : s == 1 ? error : s == 2 ? user_mode :
           s == 3 ? ~link.config_request_low : link.config_clock;
  endfunction

  task automatic end_sim();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic timeout(input int s);
    fail_count++;
    $display("ERROR t=%0t wait expired sel=%h got=%h", $time, s, 0);
    end_sim();
  endtask

  task automatic wait_on(input int s);
    int n;
    n = 0;
    while (sel(s) !== 1'b1) begin
      @(posedge i_core_clk);
      n++;
      if (n > 20000) timeout(s);
    end
  endtask

  // Push words into the host buffer, counting refusals while full
  task automatic push(input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      word <= {lfsr, ~lfsr};
      wvalid <= 1'b1;
      t = 0;
      do begin
        @(posedge i_core_clk);
        t++;
        if (word_ready !== 1'b1) refused++;
        if (t > 20000) timeout(9);
      end while (word_ready !== 1'b1);
      q.push_back({lfsr, ~lfsr});
      lfsr = lfsr_next(lfsr);
    end
    wvalid <= 1'b0;
  endtask

  task automatic run(input logic m, input logic u, input int sh, input int hl);
    mon <= m;
    use_uclk <= u;
    exp_low = (sh > RLOW) ? sh : RLOW;
    nvalid = 0;
    refused = 0;
    start <= 1'b1;
    hold <= (hl > 0);
    repeat (sh) @(posedge i_core_clk);
    start <= 1'b0;
    repeat (hl) @(posedge i_core_clk);
    hold <= 1'b0;
    push(NW);
    check({29'h0, busy, done, error}, 32'h4);
    wait_on(0);
    check({29'h0, busy, done, error}, 32'h2);
    wait_on(2);
    check(nvalid, NW);
    check(32'(refused > 0), 32'h1);
    check({29'h0, link.config_request_low, link.device_ready_low, link.load_complete},
          32'h7);
  endtask

  // Reference timing and word model
  always @(posedge i_core_clk) begin
    rq_d <= link.config_request_low;
    ck_d <= link.config_clock;
    lc_d <= link.load_complete;
    um_d <= user_mode;
    en_d <= clk_en;
    req_len <= link.config_request_low ? 0 : req_len + 1;
    since_rq <= since_rq + 1;
    lc_t <= lc_t + 1;
    en_t <= en_t + 1;
    if (cfg_valid === 1'b1) begin
      nvalid <= nvalid + 1;
      check(cfg_word, q.size() > 0 ? q.pop_front() : 'x);
    end
    if (link.config_request_low === 1'b1 && rq_d === 1'b0 && i_rst_n === 1'b1) begin
      since_rq <= 0;
      first <= 1'b1;
      check(32'(req_len >= exp_low), 32'h1);
    end
    if (link.config_clock === 1'b1 && ck_d === 1'b0 && first) begin
      first <= 1'b0;
      if (!mon) check(32'(since_rq >= CF - 2), 32'h1);
    end
    if (link.load_complete === 1'b1 && lc_d === 1'b0) lc_t <= 0;
    if (clk_en === 1'b1 && en_d === 1'b0) begin
      en_t <= 0;
      check(32'(lc_t >= `CU_CYC), 32'h1);
    end
    if (user_mode === 1'b1 && um_d === 1'b0) begin
      if (use_uclk) check(32'(en_t >= UPER * 2 * `USR_HALF_CYC - 2), 32'h1);
      else check(32'(lc_t >= OSC && lc_t <= OSC * 437 / 175), 32'h1);
    end
  end

  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    run(1'b1, 1'b0, 30, 150);
    run(1'b0, 1'b1, 1, 0);
    // Ready pulled low mid-transfer, then reset in mid-run
    mon <= 1'b1;
    exp_low = RLOW;
    start <= 1'b1;
    @(posedge i_core_clk);
    start <= 1'b0;
    push(2);
    wait_on(4);
    // Pull ready after the first fall, with the clock low
    repeat (8) @(posedge i_core_clk);
    hold <= 1'b1;
    wait_on(1);
    check(32'(error), 32'h1);
    wait_on(3);
    hold <= 1'b0;
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    check({30'h0, link.device_ready_low, link.load_complete}, 32'h0);
    q.delete();
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    run(1'b1, 1'b0, 1, 0);
    end_sim();
  end
endmodule
